// >>> bench/link_sup_checker.sv
// Concurrent checks on the ports of the link supervisor.
module link_sup_checker
    import link_sup_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       framed_rx,
    input wire logic       far_loopback,
    input wire logic       sync_lost,
    input wire logic       unframed_mode,
    input wire logic       tx_clock_bad,
    input wire logic       trunk_valid,
    input wire logic       local_loop_switch,
    input wire lamps_s     lamps,
    input wire path_s      path,
    input wire loop_mode_e loop_mode,
    input wire logic       restart
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Two ticks and 8 cycles of slack, since the pattern starts at any phase of the tick but times out on a tick.
    localparam int unsigned PAT_MAX = PATTERN_TIMEOUT_MS * TICK_DIV + 2 * TICK_DIV + 8;
    logic [31:0] pat_cnt_reg;
    logic        los_src;
    assign los_src = unframed_mode ? tx_clock_bad : sync_lost;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pat_cnt_reg <= '0;
        end else begin
            pat_cnt_reg <= path.pattern_on_line ? pat_cnt_reg + 32'h1 : '0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_link; $stable(framed_rx)[*8] |-> lamps.line_link_lamp == framed_rx; endproperty
    a_link: assert property (p_link) else $error("line link lamp wrong");
    property p_trunk; $stable(trunk_valid)[*8] |-> lamps.trunk_link_lamp == trunk_valid;
    endproperty
    a_trunk: assert property (p_trunk) else $error("trunk lamp wrong");
    property p_los; $stable(los_src)[*8] |-> lamps.sync_loss_lamp == los_src; endproperty
    a_los: assert property (p_los) else $error("sync loss lamp wrong");
    property p_tm; local_loop_switch[*8] |-> lamps.test_mode_lamp; endproperty
    a_tm: assert property (p_tm) else $error("test mode lamp dark in loop");
    property p_far; far_loopback[*8] |-> path.to_line && path.to_framer; endproperty
    a_far: assert property (p_far) else $error("far loop path wrong");
    property p_mode2; ($past(loop_mode) == LOOP_NONE && loop_mode == LOOP_MODE2)
        |-> $past(!lamps.no_signal_lamp); endproperty
    a_mode2: assert property (p_mode2) else $error("mode 2 entered while unlinked");
    property p_term; (loop_mode != LOOP_NONE)[*2] |-> path.to_terminal; endproperty
    a_term: assert property (p_term) else $error("local loop not toward terminal");
    property p_pulse; restart |=> !restart; endproperty
    a_pulse: assert property (p_pulse) else $error("restart longer than a cycle");
    property p_pat; pat_cnt_reg <= PAT_MAX; endproperty
    a_pat: assert property (p_pat) else $error("pattern outlived its timeout");
    property p_patlamp; path.pattern_on_line[*2] |-> lamps.test_mode_lamp; endproperty
    a_patlamp: assert property (p_patlamp) else $error("pattern without test lamp");
    c_restart: cover property (restart);
    c_mode2: cover property (loop_mode == LOOP_MODE2);
    c_patend: cover property ($fell(path.pattern_on_line));
endmodule
////////////////////////////////////////////////////////////////////////////////
bind link_restart_test_supervisor link_sup_checker #(.TICK_DIV(TICK_DIV)) chk_inst (
    .mclk, .rst_n, .framed_rx, .far_loopback, .sync_lost, .unframed_mode, .tx_clock_bad,
    .trunk_valid, .local_loop_switch, .lamps, .path, .loop_mode, .restart
);

// >>> bench/remote_modem.sv
// Behavioural model of the remote modem across the line.
module remote_modem (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic line_cut,
    input  wire logic echo_on,
    input  wire logic pattern_in,
    output logic      framed_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    // A looped pattern is unframed, so the local framer cannot tell it from a dead line.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            framed_rx <= 1'b0;
        end else begin
            framed_rx <= !line_cut && !(echo_on && pattern_in);
        end
    end
endmodule

// >>> bench/test_link_restart_test_supervisor.sv
// Self-checking testbench for the link supervisor.
module test_link_restart_test_supervisor;
    import link_sup_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned TDIV = 1;
    logic mclk = 1'b0;
    logic rst_n, wr, rd, framed_rx, crc_error, bit_error, rate_unsupported, mgmt_packet_ok;
    logic far_loopback, sync_lost, unframed_mode, tx_clock_bad, trunk_valid, restart, irq;
    logic pattern_switch, local_loop_switch, line_cut, echo_on, rd_q;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    lamps_s     lamps;
    path_s      path;
    loop_mode_e loop_mode;
    logic [7:0] exp_q[$];
    int         miscompares, check_count, n, r;
    link_restart_test_supervisor #(.TICK_DIV(TDIV)) link_restart_test_supervisor_inst (
        .mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .framed_rx, .crc_error, .bit_error,
        .rate_unsupported, .mgmt_packet_ok, .far_loopback, .sync_lost, .unframed_mode,
        .tx_clock_bad, .trunk_valid, .pattern_switch, .local_loop_switch, .lamps, .path,
        .loop_mode, .restart, .irq
    );
    remote_modem remote_modem_inst (
        .mclk, .rst_n, .line_cut, .echo_on, .pattern_in(path.pattern_on_line), .framed_rx
    );
    always #50 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            miscompares++;
        end
    endtask
    task automatic finish_test;
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic bound(input int cnt, input int lim);
        if (cnt >= lim) begin
            miscompares++;
            finish_test;
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        {rd, addr} <= {1'b1, a};
        exp_q.push_back(e);
        @(posedge mclk);
        rd <= 1'b0;
    endtask
    task automatic toggles(output int t);
        logic p;
        p = lamps.error_lamp;
        t = 0;
        repeat (300) begin
            @(posedge mclk);
            t += int'(lamps.error_lamp !== p);
            p = lamps.error_lamp;
        end
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there.
    always @(posedge mclk) begin
        if (rd_q) begin
            check(rdata, exp_q.pop_front());
        end
        rd_q <= rd;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h5570));
        {rst_n, wr, rd, rd_q, crc_error, bit_error, rate_unsupported, mgmt_packet_ok} = '0;
        {far_loopback, sync_lost, unframed_mode, tx_clock_bad, trunk_valid} = '0;
        {pattern_switch, local_loop_switch, echo_on, addr, wdata} = '0;
        line_cut = 1'b1;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        check(lamps.no_signal_lamp, 1'b1);
        rd_reg(ADDR_CTRL, CTRL_RESET);
        rd_reg(ADDR_MASK, MASK_RESET);
        rd_reg(4'hF, 8'h00);
        wr_reg(ADDR_STATUS, 8'hFF);
        rd_reg(ADDR_STATUS, 8'h00);
        repeat (8) begin
            @(posedge mclk);
            {sync_lost, unframed_mode, tx_clock_bad, trunk_valid} <= 4'($urandom);
            repeat (5) @(posedge mclk);
            check(lamps.sync_loss_lamp, unframed_mode ? tx_clock_bad : sync_lost);
            check(lamps.trunk_link_lamp, trunk_valid);
        end
        line_cut <= 1'b0;
        repeat (8) @(posedge mclk);
        check(lamps.line_link_lamp, 1'b1);
        check(lamps.no_signal_lamp, 1'b0);
        rd_reg(ADDR_STATUS, 8'h01);
        local_loop_switch <= 1'b1;
        repeat (8) @(posedge mclk);
        check(loop_mode, LOOP_MODE2);
        check(lamps.test_mode_lamp, 1'b1);
        check(path.to_terminal, 1'b1);
        rd_reg(ADDR_STATUS, 8'h21);
        {local_loop_switch, far_loopback} <= 2'b01;
        repeat (8) @(posedge mclk);
        check({path.to_line, path.to_framer, lamps.test_mode_lamp}, 3'h7);
        far_loopback <= 1'b0;
        wr_reg(ADDR_MASK, 8'h03);
        line_cut <= 1'b1;
        for (n = 0; !restart && n < 5000; n++) @(posedge mclk);
        bound(n, 5000);
        check(n >= DATA_RESTART_MS * TDIV - 5 && n <= DATA_RESTART_MS * TDIV + 20, 1'b1);
        repeat (2) @(posedge mclk);
        check(irq, 1'b1);
        rd_reg(ADDR_IRQ, 8'h05);
        wr_reg(ADDR_IRQ, 8'hFF);
        repeat (2) @(posedge mclk);
        check(irq, 1'b0);
        wr_reg(ADDR_CTRL, 8'h01);
        repeat (4) @(posedge mclk);
        check(loop_mode, LOOP_MODE1);
        check(lamps.test_mode_lamp, 1'b1);
        rd_reg(ADDR_CTRL, 8'h01);
        wr_reg(ADDR_CTRL, CTRL_RESET);
        {line_cut, echo_on} <= 2'b01;
        repeat (8) @(posedge mclk);
        pattern_switch <= 1'b1;
        repeat (6) @(posedge mclk);
        check({path.pattern_on_line, lamps.test_mode_lamp}, 2'h3);
        bit_error <= 1'b1;
        @(posedge mclk);
        bit_error <= 1'b0;
        repeat (4) @(posedge mclk);
        check(lamps.error_lamp, 1'b1);
        r = 0;
        for (n = 0; path.pattern_on_line && n < 50000; n++) begin
            @(posedge mclk);
            r += int'(restart);
        end
        bound(n, 50000);
        check(n >= PATTERN_TIMEOUT_MS * TDIV - 10 && n <= PATTERN_TIMEOUT_MS * TDIV + 10, 1);
        check(r, 0);
        toggles(n);
        check(n >= 2, 1'b1);
        check(irq, 1'b1);
        {pattern_switch, echo_on} <= 2'b00;
        repeat (8) @(posedge mclk);
        toggles(n);
        check(n, 0);
        crc_error <= 1'b1;
        @(posedge mclk);
        crc_error <= 1'b0;
        repeat (6) @(posedge mclk);
        check(lamps.error_lamp, 1'b1);
        mgmt_packet_ok <= 1'b1;
        @(posedge mclk);
        mgmt_packet_ok <= 1'b0;
        repeat (6) @(posedge mclk);
        check(lamps.test_mode_lamp, 1'b1);
        repeat (MGMT_FLASH_MS * TDIV + 10) @(posedge mclk);
        check(lamps.test_mode_lamp, 1'b0);
        {rate_unsupported, line_cut, rst_n} <= 3'b110;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        check(lamps.no_signal_lamp, 1'b1);
        rd_reg(ADDR_MASK, MASK_RESET);
        r = 0;
        repeat (300) begin
            @(posedge mclk);
            r += int'(lamps.test_mode_lamp);
        end
        check(r >= 100 && r <= 200, 1'b1);
        line_cut <= 1'b0;
        repeat (300) @(posedge mclk);
        check(lamps.test_mode_lamp, 1'b0);
        finish_test;
    end
endmodule

// >>> design/link_restart_test_supervisor.sv
// Supervisor for link restart, pattern test timeout, loop control and front lamps.
//
// Overview of operation
// - The line-link lamp is lit exactly while the framer reports framed packets.
// - In data mode four seconds of unbroken unframed packets cause a restart.
// - The restart interval is 50 s in start-up and 60 s with the pattern on or as far loop end.
// - The pattern generator stops itself after 45 s and the normal data path returns.
// - After a pattern timeout the error lamp blinks until the pattern switch goes to normal.
// - The error lamp flashes once per CRC error outside a pattern test, or per bit error during one.
// - At power-up only, an unsupported rate setting blinks the test-mode lamp every 200 ms.
// - The test-mode lamp glows steadily in any local or remotely requested test mode.
// - A valid management packet flashes the test-mode lamp for 400 ms.
// - The no-signal lamp is lit while there is no connection with the remote unit.
// - The sync-loss lamp shows sync loss, or the transmit clock status in unframed mode.
// - The trunk-link lamp is lit solidly while a valid trunk connection is present.
// - The pattern bypasses the framer and goes out on the line unframed.
// - A local loop returns data toward the local terminal interface.
// - A far loop returns received data to the line and still passes it to the framer.
// - A local loop enters mode 1 when unlinked and mode 2 when already linked.
module link_restart_test_supervisor
    import link_sup_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       framed_rx,
    input  wire logic       crc_error,
    input  wire logic       bit_error,
    input  wire logic       rate_unsupported,
    input  wire logic       mgmt_packet_ok,
    input  wire logic       far_loopback,
    input  wire logic       sync_lost,
    input  wire logic       unframed_mode,
    input  wire logic       tx_clock_bad,
    input  wire logic       trunk_valid,
    input  wire logic       pattern_switch,
    input  wire logic       local_loop_switch,
    output lamps_s          lamps,
    output path_s           path,
    output loop_mode_e      loop_mode,
    output logic            restart,
    output logic            irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers.

    localparam int unsigned NPIN = 12;

    logic [1:0]      rst_sync;
    logic            rst_ok_n;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_ok_n = rst_sync[1];

    assign pin_raw = {framed_rx,
                      crc_error,
                      bit_error,
                      rate_unsupported,
                      mgmt_packet_ok,
                      far_loopback,
                      sync_lost,
                      unframed_mode,
                      tx_clock_bad,
                      trunk_valid,
                      pattern_switch,
                      local_loop_switch};

    // Every pin crosses from outside; the first stage feeds only the second.
    always_ff @(posedge mclk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end

    logic s_framed;
    logic s_crc;
    logic s_bit;
    logic s_rate;
    logic s_mgmt;
    logic s_far;
    logic s_sync;
    logic s_unfr;
    logic s_txbad;
    logic s_trunk;
    logic s_pat;
    logic s_loop;
    assign {s_framed,
            s_crc,
            s_bit,
            s_rate,
            s_mgmt,
            s_far,
            s_sync,
            s_unfr,
            s_txbad,
            s_trunk,
            s_pat,
            s_loop} = pin_s2;

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [TICK_W-1:0] tick_cnt;
        logic              tick;
        link_state_e       lstate;
        logic [MS_W-1:0]   unframed_ms;
        logic [MS_W-1:0]   pattern_ms;
        logic              pattern_run;
        logic              pattern_timed_out;
        logic [MS_W-1:0]   flash_ms;
        logic [MS_W-1:0]   mgmt_ms;
        logic [MS_W-1:0]   blink_ms;
        logic              blink;
        logic              powerup;
        logic              crc_d;
        logic              bit_d;
        logic              mgmt_d;
        logic [7:0]        ctrl;
        logic [7:0]        ev;
        logic [7:0]        mask;
        logic [7:0]        rdata;
        loop_mode_e        lmode;
        lamps_s            lamps;
        path_s             path;
        logic              restart;
        logic              irq;
    } state_s;

    state_s st_reg;
    state_s st_next;

    function automatic logic [MS_W-1:0] restart_limit(input link_state_e s,
                                                      input logic pat, input logic far);
        if (pat || far) begin
            restart_limit = MS_W'(TEST_RESTART_MS);
        end else if (s == ST_STARTUP) begin
            restart_limit = MS_W'(START_RESTART_MS);
        end else begin
            restart_limit = MS_W'(DATA_RESTART_MS);
        end
    endfunction

    // Rising edge of a synchronised pin against its copy from the cycle before.
    function automatic logic rose(input logic now, input logic was);
        rose = now && !was;
    endfunction

    // Millisecond down-counter for the flash timers; it parks at zero instead of wrapping.
    function automatic logic [MS_W-1:0] count_down(input logic [MS_W-1:0] v,
                                                   input logic            tk);
        if (tk && v != '0) begin
            count_down = v - 1'b1;
        end else begin
            count_down = v;
        end
    endfunction

    // Read-only status view; the field order lives here only.
    function automatic logic [7:0] status_word(input state_s s);
        status_word = {2'b00,
                       s.lmode,
                       s.pattern_timed_out,
                       s.pattern_run,
                       1'b0,
                       s.lstate == ST_DATA};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        logic [7:0] ev_set;
        logic       loop_req;
        logic       far_req;
        logic       pat_req;
        logic       linked;
        logic       do_restart;
        ev_set   = 8'h00;
        st_next  = st_reg;
        loop_req = s_loop | st_reg.ctrl[CTRL_LOCAL_LOOP];
        far_req  = s_far | st_reg.ctrl[CTRL_FAR_LOOP];
        pat_req  = s_pat | st_reg.ctrl[CTRL_PATTERN];
        linked   = (st_reg.lstate == ST_DATA);
        do_restart = 1'b0;

        // Free-running millisecond tick.
        st_next.tick = 1'b0;
        if (st_reg.tick_cnt == TICK_W'(TICK_DIV - 1)) begin
            st_next.tick_cnt = '0;
            st_next.tick     = 1'b1;
        end else begin
            st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
        end

        // Restart supervision on consecutive unframed packets.
        if (s_framed) begin
            st_next.unframed_ms = '0;
            if (st_reg.lstate == ST_STARTUP) begin
                ev_set[EV_LINK_UP] = 1'b1;
            end
            st_next.lstate = ST_DATA;
        end else if (st_reg.tick) begin
            if (st_reg.unframed_ms + 1'b1 >= restart_limit(st_reg.lstate,
                                                            st_reg.pattern_run, far_req)) begin
                do_restart = 1'b1;
            end else begin
                st_next.unframed_ms = st_reg.unframed_ms + 1'b1;
            end
        end
        if (do_restart) begin
            st_next.unframed_ms = '0;
            st_next.lstate      = ST_STARTUP;
            ev_set[EV_RESTART]  = 1'b1;
        end
        st_next.restart = do_restart;

        // Pattern generator with self timeout; a new run needs the switch back to normal.
        if (!pat_req) begin
            st_next.pattern_run       = 1'b0;
            st_next.pattern_timed_out = 1'b0;
            st_next.pattern_ms        = '0;
        end else if (st_reg.lmode == LOOP_MODE2) begin
            // The generator has no path to the line in loop mode 2, so it is held off.
            st_next.pattern_run = 1'b0;
            st_next.pattern_ms  = '0;
        end else if (!st_reg.pattern_timed_out) begin
            st_next.pattern_run = 1'b1;
            if (st_reg.tick) begin
                if (st_reg.pattern_ms + 1'b1 >= MS_W'(PATTERN_TIMEOUT_MS)) begin
                    st_next.pattern_run       = 1'b0;
                    st_next.pattern_timed_out = 1'b1;
                    ev_set[EV_TIMEOUT]        = 1'b1;
                end else begin
                    st_next.pattern_ms = st_reg.pattern_ms + 1'b1;
                end
            end
        end

        // A stopped pattern restarts the unframed count, so the short data-mode limit does
        // not fire in the few cycles before framed packets return.
        if (st_reg.pattern_run && !st_next.pattern_run) begin
            st_next.unframed_ms = '0;
        end

        // Loop mode chosen by link status at the moment of the request.
        if (!loop_req) begin
            st_next.lmode = LOOP_NONE;
        end else if (st_reg.lmode == LOOP_NONE) begin
            st_next.lmode = linked ? LOOP_MODE2 : LOOP_MODE1;
        end

        // Data path steering.
        st_next.path.to_terminal     = (st_next.lmode != LOOP_NONE);
        st_next.path.to_line         = far_req;
        st_next.path.to_framer       = ~st_next.pattern_run;
        st_next.path.pattern_on_line = st_next.pattern_run;

        // Error flash per error edge, blink after timeout.
        st_next.crc_d = s_crc;
        st_next.bit_d = s_bit;
        if ((rose(s_crc, st_reg.crc_d) && !st_reg.pattern_run) ||
            (rose(s_bit, st_reg.bit_d) && st_reg.pattern_run)) begin
            st_next.flash_ms  = MS_W'(ERR_FLASH_MS);
            ev_set[EV_ERROR]  = 1'b1;
        end else begin
            st_next.flash_ms = count_down(st_reg.flash_ms, st_reg.tick);
        end

        // Management packet flash.
        st_next.mgmt_d = s_mgmt;
        if (rose(s_mgmt, st_reg.mgmt_d)) begin
            st_next.mgmt_ms = MS_W'(MGMT_FLASH_MS);
        end else begin
            st_next.mgmt_ms = count_down(st_reg.mgmt_ms, st_reg.tick);
        end

        // Shared blink base, one toggle per half rate period.
        if (st_reg.tick) begin
            if (st_reg.blink_ms + 1'b1 >= MS_W'(RATE_BLINK_MS / 2)) begin
                st_next.blink_ms = '0;
                st_next.blink    = ~st_reg.blink;
            end else begin
                st_next.blink_ms = st_reg.blink_ms + 1'b1;
            end
        end
        // Power-up window ends at the first link; the rate check is not repeated later.
        if (st_reg.lstate == ST_DATA) begin
            st_next.powerup = 1'b0;
        end

        // Lamps.
        st_next.lamps.line_link_lamp  = s_framed;
        st_next.lamps.no_signal_lamp  = (st_next.lstate == ST_STARTUP);
        st_next.lamps.sync_loss_lamp  = s_unfr ? s_txbad : s_sync;
        st_next.lamps.trunk_link_lamp = s_trunk;
        st_next.lamps.error_lamp      = st_next.pattern_timed_out ? st_reg.blink
                                                                  : (st_next.flash_ms != '0);
        if (st_reg.powerup && s_rate) begin
            st_next.lamps.test_mode_lamp = st_reg.blink;
        end else begin
            st_next.lamps.test_mode_lamp = (st_next.lmode != LOOP_NONE) || far_req ||
                                           st_next.pattern_run || (st_next.mgmt_ms != '0);
        end

        // Register port: IRQ bits write-one-to-clear, set wins over clear.
        st_next.rdata = 8'h00;
        if (wr) begin
            case (addr)
                ADDR_CTRL: st_next.ctrl = wdata;
                ADDR_IRQ:  st_next.ev   = st_reg.ev & ~wdata;
                ADDR_MASK: st_next.mask = wdata;
                default:   ;
            endcase
        end
        st_next.ev = st_next.ev | ev_set;
        if (rd) begin
            case (addr)
                ADDR_CTRL:   st_next.rdata = st_reg.ctrl;
                ADDR_STATUS: st_next.rdata = status_word(st_reg);
                ADDR_IRQ:    st_next.rdata = st_reg.ev;
                ADDR_MASK:   st_next.rdata = st_reg.mask;
                default:     st_next.rdata = 8'h00;
            endcase
        end
        st_next.irq = |(st_next.ev & st_next.mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge mclk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            st_reg                      <= '0;
            st_reg.lstate               <= ST_STARTUP;
            st_reg.lmode                <= LOOP_NONE;
            st_reg.powerup              <= 1'b1;
            st_reg.ctrl                 <= CTRL_RESET;
            st_reg.mask                 <= MASK_RESET;
            st_reg.lamps.no_signal_lamp <= 1'b1;
            st_reg.path.to_framer       <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata     = st_reg.rdata;
    assign lamps     = st_reg.lamps;
    assign path      = st_reg.path;
    assign loop_mode = st_reg.lmode;
    assign restart   = st_reg.restart;
    assign irq       = st_reg.irq;

endmodule

// >>> design/link_sup_pkg.sv
// Package with constants and carrier types for the link restart and test supervisor.
package link_sup_pkg;

    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned TICK_MS          = 1;
    localparam int unsigned TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned DATA_RESTART_S   = 4;
    localparam int unsigned START_RESTART_S  = 50;
    localparam int unsigned TEST_RESTART_S   = 60;
    localparam int unsigned PATTERN_TIMEOUT_S = 45;
    localparam int unsigned RATE_BLINK_MS    = 200;
    localparam int unsigned MGMT_FLASH_MS    = 400;
    localparam int unsigned ERR_FLASH_MS     = 100;
    localparam int unsigned TIMEOUT_BLINK_MS = 250;
    localparam int unsigned DATA_RESTART_MS  = DATA_RESTART_S * 1000;
    localparam int unsigned START_RESTART_MS = START_RESTART_S * 1000;
    localparam int unsigned TEST_RESTART_MS  = TEST_RESTART_S * 1000;
    localparam int unsigned PATTERN_TIMEOUT_MS = PATTERN_TIMEOUT_S * 1000;
    localparam int unsigned MS_W             = 16;
    localparam int unsigned TICK_W           = 14;

    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_IRQ    = 4'h2;
    localparam logic [3:0] ADDR_MASK   = 4'h3;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam int unsigned CTRL_LOCAL_LOOP = 0;
    localparam int unsigned CTRL_FAR_LOOP   = 1;
    localparam int unsigned CTRL_PATTERN    = 2;
    localparam int unsigned EV_RESTART  = 0;
    localparam int unsigned EV_TIMEOUT  = 1;
    localparam int unsigned EV_LINK_UP  = 2;
    localparam int unsigned EV_ERROR    = 3;

    typedef enum logic [1:0] {
        ST_STARTUP,
        ST_DATA
    } link_state_e;

    typedef enum logic [1:0] {
        LOOP_NONE,
        LOOP_MODE1,
        LOOP_MODE2
    } loop_mode_e;

    typedef struct packed {
        logic no_signal_lamp;
        logic error_lamp;
        logic test_mode_lamp;
        logic sync_loss_lamp;
        logic line_link_lamp;
        logic trunk_link_lamp;
    } lamps_s;

    typedef struct packed {
        logic to_terminal;
        logic to_line;
        logic to_framer;
        logic pattern_on_line;
    } path_s;

endpackage
